//--- hw/lac_top.sv
// Link aggregation control: membership negotiation, identifiers and frame distribution
//
// Functional notes
// - On mode: member ports send no control frames and ignore received ones.
// - Active mode: each port sends control frames at a fixed periodic interval.
// - Passive mode: port stays silent until a partner control frame arrives.
// - In active or passive mode, link joins group only when link is up and partner agrees; on mode joins without a partner.
// - Ports attach or detach following the partner's exchanged aggregation state.
// - In active or passive mode, forwarding is enabled only after the partner reports synchronized; on mode forwards at once.
// - System identifier is priority concatenated with a global individual MAC.
// - Port identifier is port priority concatenated with unique port number.
// - Each port has admin key and an operational key from its aggregatability.
// - Aggregator carries a configured integer identifier readable by software.
// - Six selectable unicast hashes over MAC/VLAN/inport or IP/L4 fields.
// - Configured hash only for learned unicast; otherwise both-IP-L4 hash.
// - A failed member is dropped; traffic continues on remaining members.
// - No hot-standby state and no marker frame generator are provided.
// - Loopback or laser shutdown requests on a bundled group are rejected.
//
// Strobed register access and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module lac_top #(
    parameter int PERIOD_CYCLES = lac_pkg::PERIOD_CYCLES
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic [3:0] link_up_pin,
    input wire logic [3:0] rx_pdu_valid,
    input wire logic [3:0] rx_partner_agg,
    input wire logic [3:0] rx_partner_sync,
    output logic [3:0] tx_pdu_req,
    output logic [3:0] tx_actor_sync,
    output logic [3:0] fwd_enable,
    input wire logic frm_valid,
    input wire logic frm_unicast,
    input wire logic frm_da_learned,
    input wire logic [47:0] frm_src_mac,
    input wire logic [47:0] frm_dst_mac,
    input wire logic [11:0] frm_vlan,
    input wire logic [3:0] frm_inport,
    input wire logic [31:0] frm_src_ip,
    input wire logic [31:0] frm_dst_ip,
    input wire logic [15:0] frm_src_l4,
    input wire logic [15:0] frm_dst_l4,
    output logic egr_valid,
    output logic [1:0] egr_port,
    output logic egr_drop,
    output logic irq
);
    typedef struct packed {
        logic [1:0] mode;
        logic [2:0] hash;
        logic bundle_en;
        logic loop_en;
        logic als_en;
        logic [15:0] sys_prio;
        logic [47:0] sys_mac;
        logic [15:0] admin_key;
        logic [15:0] agg_id;
        logic [3:0][7:0] port_prio;
        logic [2:0] int_status;
        logic [2:0] int_mask;
        logic [31:0] rdata;
        logic irq;
        logic [3:0] link_s1;
        logic [3:0] link_s2;
        lac_pkg::lac_port_state_type [3:0] ps;
        logic [3:0] partner_seen;
        logic [27:0] tmr;
        logic tick;
        logic [3:0] tx_req;
        logic [3:0] fwd;
        logic egr_valid;
        logic [1:0] egr_port;
        logic egr_drop;
    } lac_state_type;

    lac_state_type s;
    lac_state_type next_s;
    logic [63:0] sys_id;
    logic [3:0][15:0] oper_key;
    logic [3:0][15:0] port_id;
    logic [63:0] hkey;
    logic [2:0] hsel;
    logic [1:0] hval;
    logic [1:0] idx;
    logic found;
    logic [1:0] pick;
    logic [2:0] ev;
    logic req_b;
    logic req_l;
    logic req_a;

    function automatic logic [1:0] lac_fold(input logic [63:0] v);
        logic [1:0] f;
        f = 2'h0;
        for (int i = 0; i < 32; i++) begin
            f = f ^ v[2*i +: 2];
        end
        return f;
    endfunction

    // Group identity is fixed to a globally administered individual address
    assign sys_id = {s.sys_prio, s.sys_mac[47:42], 2'h0, s.sys_mac[39:0]};

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            port_id[i] = {s.port_prio[i], 8'(i + 1)};
            // A port that cannot aggregate gets its own key so it stays individual
            oper_key[i] = (s.bundle_en && s.link_s2[i]) ? s.admin_key : (lac_pkg::INDIV_KEY_BASE | 16'(i));
        end
    end

    // Non-learned or non-unicast traffic falls back to the both-IP hash
    assign hsel = (frm_unicast && frm_da_learned) ? s.hash : lac_pkg::HASH_BOTH_IP_L4;

    always_comb begin
        unique case (hsel)
            lac_pkg::HASH_SRC_MAC_VLAN_INPORT: hkey = {frm_src_mac, frm_vlan, frm_inport};
            lac_pkg::HASH_DST_MAC_VLAN_INPORT: hkey = {frm_dst_mac, frm_vlan, frm_inport};
            lac_pkg::HASH_BOTH_MAC_VLAN_INPORT: hkey = {frm_src_mac ^ frm_dst_mac, frm_vlan, frm_inport};
            lac_pkg::HASH_SRC_IP_L4: hkey = {frm_src_ip, frm_src_l4, 16'h0000};
            lac_pkg::HASH_DST_IP_L4: hkey = {frm_dst_ip, frm_dst_l4, 16'h0000};
            default: hkey = {frm_src_ip ^ frm_dst_ip, frm_src_l4, frm_dst_l4};
        endcase
    end

    assign hval = lac_fold(hkey);

    // Walk from the hashed slot to the next live member; stable while membership holds
    always_comb begin
        found = 1'b0;
        pick = 2'h0;
        idx = 2'h0;
        for (int k = 0; k < 4; k++) begin
            idx = 2'(hval + 2'(k));
            if (!found && s.fwd[idx]) begin
                found = 1'b1;
                pick = idx;
            end
        end
    end

    assign req_b = wdata[lac_pkg::CTRL_BUNDLE];
    assign req_l = wdata[lac_pkg::CTRL_LOOP];
    assign req_a = wdata[lac_pkg::CTRL_ALS];

    always_comb begin
        next_s = s;
        ev = 3'h0;
        next_s.link_s1 = link_up_pin;
        next_s.link_s2 = s.link_s1;

        // Periodic tick shared by all ports
        next_s.tick = 1'b0;
        if (s.tmr == 28'(PERIOD_CYCLES - 1)) begin
            next_s.tmr = 28'h0000000;
            next_s.tick = 1'b1;
        end else begin
            next_s.tmr = s.tmr + 28'h0000001;
        end

        // Hot standby is deliberately absent: a member forwards or is out
        for (int i = 0; i < 4; i++) begin
            next_s.tx_req[i] = 1'b0;
            if (!s.link_s2[i] || !s.bundle_en) begin
                if (s.ps[i] == lac_pkg::PS_ATTACHED || s.ps[i] == lac_pkg::PS_FORWARD) begin
                    ev[lac_pkg::INT_FAIL] = 1'b1;
                end
                next_s.ps[i] = lac_pkg::PS_DOWN;
                next_s.partner_seen[i] = 1'b0;
            end else if (s.mode != lac_pkg::MODE_ACTIVE && s.mode != lac_pkg::MODE_PASSIVE) begin
                // Static bundle: frames from the partner are not acted upon
                if (s.ps[i] != lac_pkg::PS_FORWARD) begin
                    ev[lac_pkg::INT_ATTACH] = 1'b1;
                end
                next_s.ps[i] = lac_pkg::PS_FORWARD;
                next_s.partner_seen[i] = 1'b0;
            end else begin
                if (rx_pdu_valid[i]) begin
                    next_s.partner_seen[i] = 1'b1;
                end
                unique case (s.ps[i])
                    lac_pkg::PS_DOWN: begin
                        next_s.ps[i] = lac_pkg::PS_WAIT;
                    end
                    lac_pkg::PS_WAIT: begin
                        if (rx_pdu_valid[i] && rx_partner_agg[i]) begin
                            next_s.ps[i] = lac_pkg::PS_ATTACHED;
                            ev[lac_pkg::INT_ATTACH] = 1'b1;
                        end
                    end
                    lac_pkg::PS_ATTACHED: begin
                        if (rx_pdu_valid[i] && !rx_partner_agg[i]) begin
                            next_s.ps[i] = lac_pkg::PS_WAIT;
                        end else if (rx_pdu_valid[i] && rx_partner_sync[i]) begin
                            next_s.ps[i] = lac_pkg::PS_FORWARD;
                        end
                    end
                    lac_pkg::PS_FORWARD: begin
                        if (rx_pdu_valid[i] && !rx_partner_agg[i]) begin
                            next_s.ps[i] = lac_pkg::PS_WAIT;
                        end else if (rx_pdu_valid[i] && !rx_partner_sync[i]) begin
                            next_s.ps[i] = lac_pkg::PS_ATTACHED;
                        end
                    end
                endcase
                // Only periodic frames; no marker frames are ever generated
                if (s.tick && (s.mode == lac_pkg::MODE_ACTIVE || s.partner_seen[i])) begin
                    next_s.tx_req[i] = 1'b1;
                end
            end
            next_s.fwd[i] = (next_s.ps[i] == lac_pkg::PS_FORWARD);
        end

        // Distribution result registered one cycle after the header
        next_s.egr_valid = frm_valid;
        next_s.egr_port = frm_valid ? pick : 2'h0;
        next_s.egr_drop = frm_valid && !found;

        // Register writes
        if (wr) begin
            unique case (addr)
                lac_pkg::REG_CTRL: begin
                    next_s.mode = wdata[lac_pkg::CTRL_MODE_LSB +: 2];
                    next_s.hash = wdata[lac_pkg::CTRL_HASH_LSB +: 3];
                    next_s.bundle_en = req_b;
                    if (req_b && (req_l || req_a)) begin
                        // The bundle wins; the conflicting test modes are dropped
                        next_s.loop_en = 1'b0;
                        next_s.als_en = 1'b0;
                        ev[lac_pkg::INT_REJECT] = 1'b1;
                    end else begin
                        next_s.loop_en = req_l;
                        next_s.als_en = req_a;
                    end
                end
                lac_pkg::REG_SYS_PRIO: next_s.sys_prio = wdata[15:0];
                lac_pkg::REG_SYS_MAC_LO: next_s.sys_mac[31:0] = wdata;
                lac_pkg::REG_SYS_MAC_HI: next_s.sys_mac[47:32] = wdata[15:0];
                lac_pkg::REG_ADMIN_KEY: next_s.admin_key = wdata[15:0];
                lac_pkg::REG_AGG_ID: next_s.agg_id = wdata[15:0];
                lac_pkg::REG_PORT_PRIO: next_s.port_prio = wdata;
                lac_pkg::REG_INT_MASK: next_s.int_mask = wdata[2:0];
                lac_pkg::REG_INT_STATUS: next_s.int_status = s.int_status & ~wdata[2:0];
                default: begin
                end
            endcase
        end
        // New events win over a clear in the same cycle
        next_s.int_status = next_s.int_status | ev;
        // Mask taken from the next value too, so the line follows status and mask with no lag
        next_s.irq = |(next_s.int_status & next_s.int_mask);

        // Register reads, data valid in the following cycle only
        next_s.rdata = 32'h00000000;
        if (rd) begin
            unique case (addr)
                lac_pkg::REG_CTRL: next_s.rdata = {24'h000000, s.als_en, s.loop_en, s.bundle_en, s.hash, s.mode};
                lac_pkg::REG_SYS_PRIO: next_s.rdata = {16'h0000, s.sys_prio};
                lac_pkg::REG_SYS_MAC_LO: next_s.rdata = s.sys_mac[31:0];
                lac_pkg::REG_SYS_MAC_HI: next_s.rdata = {16'h0000, s.sys_mac[47:32]};
                lac_pkg::REG_ADMIN_KEY: next_s.rdata = {16'h0000, s.admin_key};
                lac_pkg::REG_AGG_ID: next_s.rdata = {16'h0000, s.agg_id};
                lac_pkg::REG_PORT_PRIO: next_s.rdata = s.port_prio;
                lac_pkg::REG_PORT_STATUS: next_s.rdata = {16'h0000, s.partner_seen, s.fwd, s.ps};
                lac_pkg::REG_INT_STATUS: next_s.rdata = {29'h00000000, s.int_status};
                lac_pkg::REG_INT_MASK: next_s.rdata = {29'h00000000, s.int_mask};
                lac_pkg::REG_SYS_ID_LO: next_s.rdata = sys_id[31:0];
                lac_pkg::REG_SYS_ID_HI: next_s.rdata = sys_id[63:32];
                lac_pkg::REG_PORT_INFO: next_s.rdata = {port_id[0], oper_key[0]};
                8'h34: next_s.rdata = {port_id[1], oper_key[1]};
                8'h38: next_s.rdata = {port_id[2], oper_key[2]};
                8'h3C: next_s.rdata = {port_id[3], oper_key[3]};
                default: next_s.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
            s.sys_prio <= lac_pkg::RST_SYS_PRIO;
            s.admin_key <= lac_pkg::RST_ADMIN_KEY;
            s.agg_id <= lac_pkg::RST_AGG_ID;
            s.port_prio <= {4{lac_pkg::RST_PORT_PRIO}};
            s.ps <= {4{lac_pkg::PS_DOWN}};
        end else begin
            s <= next_s;
        end
    end

    assign rdata = s.rdata;
    assign tx_pdu_req = s.tx_req;
    assign tx_actor_sync = s.fwd;
    assign fwd_enable = s.fwd;
    assign egr_valid = s.egr_valid;
    assign egr_port = s.egr_port;
    assign egr_drop = s.egr_drop;
    assign irq = s.irq;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    property p_on_silent;
        (s.mode == lac_pkg::MODE_ON) |=> (tx_pdu_req == 4'h0);
    endproperty
    a_on_silent: assert property (p_on_silent) else $error("control frame sent in on mode");

    property p_active_tx;
        (s.tick && s.mode == lac_pkg::MODE_ACTIVE && s.bundle_en && s.link_s2[0]) |=> tx_pdu_req[0];
    endproperty
    a_active_tx: assert property (p_active_tx) else $error("active port missed periodic frame");

    property p_passive_quiet;
        (s.mode == lac_pkg::MODE_PASSIVE && !s.partner_seen[0]) |=> !tx_pdu_req[0];
    endproperty
    a_passive_quiet: assert property (p_passive_quiet) else $error("passive port spoke first");

    property p_attach_cause;
        (s.ps[0] == lac_pkg::PS_ATTACHED && $past(s.ps[0]) == lac_pkg::PS_WAIT)
            |-> $past(rx_pdu_valid[0] && rx_partner_agg[0] && s.link_s2[0]);
    endproperty
    a_attach_cause: assert property (p_attach_cause) else $error("attach without partner agreement");

    property p_fwd_sync;
        ($rose(fwd_enable[0]) && ($past(s.mode) == lac_pkg::MODE_ACTIVE || $past(s.mode) == lac_pkg::MODE_PASSIVE))
            |-> $past(rx_pdu_valid[0] && rx_partner_sync[0]);
    endproperty
    a_fwd_sync: assert property (p_fwd_sync) else $error("forwarding before partner sync");

    property p_fail_drop;
        !s.link_s2[0] |=> !fwd_enable[0] ##1 (!fwd_enable[0] || s.link_s2[0]);
    endproperty
    a_fail_drop: assert property (p_fail_drop) else $error("failed port kept forwarding");

    property p_egress_member;
        (egr_valid && !egr_drop) |-> (($past(fwd_enable) >> egr_port) & 4'h1) == 4'h1;
    endproperty
    a_egress_member: assert property (p_egress_member) else $error("egress to non-member port");

    property p_reject;
        (wr && addr == lac_pkg::REG_CTRL && req_b && req_l) |=> (!s.loop_en && s.int_status[lac_pkg::INT_REJECT]);
    endproperty
    a_reject: assert property (p_reject) else $error("loopback accepted on bundle");

    property p_fallback_hash;
        (frm_valid && !(frm_unicast && frm_da_learned)) |-> (hsel == lac_pkg::HASH_BOTH_IP_L4);
    endproperty
    a_fallback_hash: assert property (p_fallback_hash) else $error("wrong hash for unlearned traffic");

    property p_irq;
        irq == (|(s.int_status & s.int_mask));
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt not raised");

    c_attach: cover property (s.ps[0] == lac_pkg::PS_WAIT ##1 s.ps[0] == lac_pkg::PS_ATTACHED);
    c_forward: cover property ($rose(fwd_enable[1]) && s.mode == lac_pkg::MODE_PASSIVE);
    c_reject: cover property ($rose(s.int_status[lac_pkg::INT_REJECT]));
    c_egress: cover property (egr_valid && !egr_drop && egr_port == 2'h3);
endmodule
`default_nettype wire

//--- pkg/lac_pkg.sv
// Constants, register map and types for the link aggregation control block
package lac_pkg;
    localparam int NUM_PORTS = 4;
    localparam int PORT_W = 2;
    localparam int ADDR_W = 8;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_SYS_PRIO = 8'h04;
    localparam logic [7:0] REG_SYS_MAC_LO = 8'h08;
    localparam logic [7:0] REG_SYS_MAC_HI = 8'h0C;
    localparam logic [7:0] REG_ADMIN_KEY = 8'h10;
    localparam logic [7:0] REG_AGG_ID = 8'h14;
    localparam logic [7:0] REG_PORT_PRIO = 8'h18;
    localparam logic [7:0] REG_PORT_STATUS = 8'h1C;
    localparam logic [7:0] REG_INT_STATUS = 8'h20;
    localparam logic [7:0] REG_INT_MASK = 8'h24;
    localparam logic [7:0] REG_SYS_ID_LO = 8'h28;
    localparam logic [7:0] REG_SYS_ID_HI = 8'h2C;
    localparam logic [7:0] REG_PORT_INFO = 8'h30;
    // Control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_HASH_LSB = 2;
    localparam int CTRL_BUNDLE = 5;
    localparam int CTRL_LOOP = 6;
    localparam int CTRL_ALS = 7;
    // Interrupt bits
    localparam int INT_W = 3;
    localparam int INT_ATTACH = 0;
    localparam int INT_FAIL = 1;
    localparam int INT_REJECT = 2;
    // Bundling modes
    localparam logic [1:0] MODE_ON = 2'h0;
    localparam logic [1:0] MODE_ACTIVE = 2'h1;
    localparam logic [1:0] MODE_PASSIVE = 2'h2;
    // Distribution hash codes
    localparam logic [2:0] HASH_SRC_MAC_VLAN_INPORT = 3'h0;
    localparam logic [2:0] HASH_DST_MAC_VLAN_INPORT = 3'h1;
    localparam logic [2:0] HASH_BOTH_MAC_VLAN_INPORT = 3'h2;
    localparam logic [2:0] HASH_SRC_IP_L4 = 3'h3;
    localparam logic [2:0] HASH_DST_IP_L4 = 3'h4;
    localparam logic [2:0] HASH_BOTH_IP_L4 = 3'h5;
    // Reset values
    localparam logic [15:0] RST_SYS_PRIO = 16'h8000;
    localparam logic [15:0] RST_ADMIN_KEY = 16'h0001;
    localparam logic [15:0] RST_AGG_ID = 16'h0001;
    localparam logic [7:0] RST_PORT_PRIO = 8'h80;
    localparam logic [15:0] INDIV_KEY_BASE = 16'h8000;
    // Periodic control frame interval
    localparam int PERIOD_US = 1000000;
    localparam int CLK_MHZ = 250;
    localparam int PERIOD_CYCLES = PERIOD_US * CLK_MHZ;
    localparam int TMR_W = 28;
    typedef enum logic [1:0] {PS_DOWN, PS_WAIT, PS_ATTACHED, PS_FORWARD} lac_port_state_type;
endpackage

//--- test/lac_peer.sv
// Peer switch model that sends control frame pulses toward the block
`timescale 1ns/100ps
`default_nettype none
module lac_peer (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [3:0] tx_pdu_req,
    input wire logic [3:0] send,
    input wire logic echo,
    input wire logic agg,
    input wire logic sync,
    output logic [3:0] rx_pdu_valid,
    output logic [3:0] rx_partner_agg,
    output logic [3:0] rx_partner_sync
);
    logic [3:0] fire;
    // Answers our frames one cycle later when echo is set; slow answers come from explicit sends
    assign fire = send | (echo ? tx_pdu_req : 4'h0);
    // Flags only mean something beside a pulse; in between they toggle so a stale value is never trusted
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rx_pdu_valid <= 4'h0;
            rx_partner_agg <= 4'h0;
            rx_partner_sync <= 4'h0;
        end else begin
            rx_pdu_valid <= fire;
            for (int i = 0; i < 4; i++) begin
                rx_partner_agg[i] <= fire[i] ? agg : ~rx_partner_agg[i];
                rx_partner_sync[i] <= fire[i] ? sync : ~rx_partner_sync[i];
            end
        end
    end
endmodule
`default_nettype wire

//--- test/tb.sv
// Self-checking testbench for the link aggregation control block
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clock = 1'h0;
    logic arst_n = 1'h0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'h0, rd = 1'h0, echo = 1'h0, agg = 1'h0, sync = 1'h0;
    logic [3:0] link_up_pin = 4'h0, send = 4'h0;
    logic [3:0] rx_pdu_valid, rx_partner_agg, rx_partner_sync, tx_pdu_req, tx_actor_sync, fwd_enable;
    logic frm_valid = 1'h0, frm_unicast = 1'h0, frm_da_learned = 1'h0;
    logic [47:0] frm_src_mac = 48'h0, frm_dst_mac = 48'h0;
    logic [11:0] frm_vlan = 12'h0;
    logic [3:0] frm_inport = 4'h0;
    logic [31:0] frm_src_ip = 32'h0, frm_dst_ip = 32'h0, rdata, rv;
    logic [15:0] frm_src_l4 = 16'h0, frm_dst_l4 = 16'h0;
    logic egr_valid, egr_drop, irq;
    logic [1:0] egr_port;
    int mismatches = 0, tests_run = 0, cycles = 0, fseq = 0;
    int txcnt [4];
    lac_top #(.PERIOD_CYCLES(8)) dut_u (.clock, .arst_n, .addr, .wdata, .wr, .rd, .rdata, .link_up_pin,
        .rx_pdu_valid, .rx_partner_agg, .rx_partner_sync, .tx_pdu_req, .tx_actor_sync, .fwd_enable, .frm_valid,
        .frm_unicast, .frm_da_learned, .frm_src_mac, .frm_dst_mac, .frm_vlan, .frm_inport, .frm_src_ip,
        .frm_dst_ip, .frm_src_l4, .frm_dst_l4, .egr_valid, .egr_port, .egr_drop, .irq);
    lac_peer peer_u (.clock, .arst_n, .tx_pdu_req, .send, .echo, .agg, .sync, .rx_pdu_valid, .rx_partner_agg,
        .rx_partner_sync);
    always #2 clock = ~clock;
    // The whole run needs about 450 cycles; the ceiling leaves ample margin
    always @(posedge clock) begin
        cycles++;
        for (int i = 0; i < 4; i++) if (tx_pdu_req[i] === 1'h1) txcnt[i]++;
        if (cycles == 6000) begin
            mismatches++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a; wdata <= d; wr <= 1'h1;
        @(posedge clock);
        wr <= 1'h0;
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr <= a; rd <= 1'h1;
        @(posedge clock);
        rd <= 1'h0;
        #1 rv = rdata;
        chk(name, rv, exp);
    endtask
    task automatic peer_pdu(input logic [3:0] p, input logic a, input logic s);
        @(posedge clock);
        send <= p; agg <= a; sync <= s;
        @(posedge clock);
        send <= 4'h0;
    endtask
    task automatic count_tx(input int p, input int exp);
        txcnt[p] = 0;
        cyc(32);
        chk("tx_count", txcnt[p], exp);
    endtask
    task automatic frame(input logic uni, input logic lrn, input logic [2:0] h, input logic [3:0] fwd);
        logic [31:0] s;
        logic [63:0] key;
        logic [1:0] idx, p;
        fseq++;
        s = fseq * 32'h9E3779B1;
        case ((uni && lrn) ? h : 3'h5)
            3'h0: key = {s[15:0], s, s[27:16], s[3:0]};
            3'h1: key = {s, ~s[15:0], s[27:16], s[3:0]};
            3'h2: key = {{s[15:0], s} ^ {s, ~s[15:0]}, s[27:16], s[3:0]};
            3'h3: key = {~s, s[31:16], 16'h0};
            3'h4: key = {s[7:0], s[31:8], s[15:0] ^ 16'h1F2E, 16'h0};
            default: key = {~s ^ {s[7:0], s[31:8]}, s[31:16], s[15:0] ^ 16'h1F2E};
        endcase
        idx = 2'h0;
        for (int j = 0; j < 32; j++) idx ^= key[2*j +: 2];
        p = idx;
        while (fwd != 4'h0 && !fwd[p]) p++;
        @(posedge clock);
        frm_valid <= 1'h1; frm_unicast <= uni; frm_da_learned <= lrn; frm_vlan <= s[27:16];
        frm_src_mac <= {s[15:0], s}; frm_dst_mac <= {s, ~s[15:0]}; frm_inport <= s[3:0];
        frm_src_ip <= ~s; frm_dst_ip <= {s[7:0], s[31:8]}; frm_src_l4 <= s[31:16]; frm_dst_l4 <= s[15:0] ^ 16'h1F2E;
        @(posedge clock);
        frm_valid <= 1'h0;
        #1;
        chk("egr_valid", egr_valid, 1'h1);
        chk("egr_drop", egr_drop, fwd == 4'h0);
        if (fwd != 4'h0) chk("egr_port", egr_port, p);
    endtask
    task automatic t_regs();
        rd_chk("ctrl", lac_pkg::REG_CTRL, 32'h0);
        rd_chk("sys_prio", lac_pkg::REG_SYS_PRIO, 32'h8000);
        rd_chk("admin_key", lac_pkg::REG_ADMIN_KEY, 32'h1);
        rd_chk("agg_id", lac_pkg::REG_AGG_ID, 32'h1);
        rd_chk("port_prio", lac_pkg::REG_PORT_PRIO, 32'h80808080);
        // Read data must fall back to zero the cycle after a non-zero read
        cyc(1);
        chk("rdata_idle", rdata, 32'h0);
        rd_chk("unmapped", 8'h40, 32'h0);
        for (int i = 0; i < 4; i++) rd_chk("port_info", 8'h30 + 8'(4 * i), {8'h80, 8'(i + 1), 16'h8000 | 16'(i)});
        reg_wr(lac_pkg::REG_SYS_MAC_LO, 32'h44332211);
        reg_wr(lac_pkg::REG_SYS_MAC_HI, 32'hFFFF);
        reg_wr(lac_pkg::REG_AGG_ID, 32'h7);
        rd_chk("sys_id_lo", lac_pkg::REG_SYS_ID_LO, 32'h44332211);
        rd_chk("sys_id_hi", lac_pkg::REG_SYS_ID_HI, 32'h8000FCFF);
        reg_wr(lac_pkg::REG_SYS_PRIO, 32'h1234);
        rd_chk("sys_id_hi", lac_pkg::REG_SYS_ID_HI, 32'h1234FCFF);
        rd_chk("agg_id", lac_pkg::REG_AGG_ID, 32'h7);
        $display("test regs done");
    endtask
    task automatic t_reject();
        reg_wr(lac_pkg::REG_CTRL, 32'h40);
        rd_chk("ctrl", lac_pkg::REG_CTRL, 32'h40);
        rd_chk("int_status", lac_pkg::REG_INT_STATUS, 32'h0);
        reg_wr(lac_pkg::REG_CTRL, 32'hE0);
        rd_chk("ctrl", lac_pkg::REG_CTRL, 32'h20);
        rd_chk("int_status", lac_pkg::REG_INT_STATUS, 32'h4);
        chk("irq", irq, 1'h0);
        reg_wr(lac_pkg::REG_INT_MASK, 32'h4);
        cyc(2);
        chk("irq", irq, 1'h1);
        reg_wr(lac_pkg::REG_INT_STATUS, 32'h4);
        cyc(2);
        chk("irq", irq, 1'h0);
        $display("test reject done");
    endtask
    task automatic t_on_dist();
        @(posedge clock) link_up_pin <= 4'hF;
        cyc(8);
        chk("fwd_enable", fwd_enable, 4'hF);
        count_tx(3, 0);
        peer_pdu(4'hF, 1'h0, 1'h0);
        cyc(3);
        chk("fwd_enable", fwd_enable, 4'hF);
        // Codes 6 and 7 must behave as the both-IP hash
        for (int h = 0; h < 8; h++) begin
            reg_wr(lac_pkg::REG_CTRL, 32'h20 | (h << 2));
            repeat (3) frame(1'h1, 1'h1, 3'(h), 4'hF);
        end
        // A non-IP hash is configured so the fallback is visible
        reg_wr(lac_pkg::REG_CTRL, 32'h20);
        frame(1'h0, 1'h1, 3'h0, 4'hF);
        frame(1'h1, 1'h0, 3'h0, 4'hF);
        @(posedge clock) link_up_pin <= 4'hB;
        cyc(6);
        for (int k = 0; k < 8; k++) frame(1'h1, 1'h1, 3'h0, 4'hB);
        @(posedge clock) link_up_pin <= 4'h0;
        cyc(6);
        frame(1'h1, 1'h1, 3'h0, 4'h0);
        $display("test on and distribution done");
    endtask
    task automatic t_active();
        reg_wr(lac_pkg::REG_CTRL, 32'h21);
        reg_wr(lac_pkg::REG_INT_STATUS, 32'h7);
        @(posedge clock) link_up_pin <= 4'h1;
        cyc(6);
        count_tx(0, 4);
        chk("fwd_enable", fwd_enable, 4'h0);
        peer_pdu(4'h1, 1'h1, 1'h0);
        cyc(2);
        chk("fwd_enable", fwd_enable, 4'h0);
        rd_chk("port_status", lac_pkg::REG_PORT_STATUS, 32'h1002);
        peer_pdu(4'h1, 1'h1, 1'h1);
        cyc(2);
        chk("fwd_enable", fwd_enable, 4'h1);
        chk("actor_sync", tx_actor_sync, 4'h1);
        peer_pdu(4'h1, 1'h0, 1'h1);
        cyc(2);
        chk("fwd_enable", fwd_enable, 4'h0);
        @(posedge clock) echo <= 1'h1; agg <= 1'h1; sync <= 1'h1;
        for (int n = 0; n < 40 && fwd_enable[0] !== 1'h1; n++) cyc(1);
        chk("fwd_enable", fwd_enable, 4'h1);
        @(posedge clock) echo <= 1'h0;
        reg_wr(lac_pkg::REG_INT_MASK, 32'h2);
        reg_wr(lac_pkg::REG_INT_STATUS, 32'h7);
        @(posedge clock) link_up_pin <= 4'h0;
        cyc(6);
        chk("irq", irq, 1'h1);
        chk("fwd_enable", fwd_enable, 4'h0);
        $display("test active done");
    endtask
    task automatic t_passive();
        reg_wr(lac_pkg::REG_CTRL, 32'h22);
        @(posedge clock) link_up_pin <= 4'h2;
        cyc(6);
        count_tx(1, 0);
        rd_chk("port_info", 8'h34, 32'h80020001);
        peer_pdu(4'h2, 1'h1, 1'h0);
        cyc(10);
        count_tx(1, 4);
        peer_pdu(4'h2, 1'h1, 1'h1);
        cyc(2);
        chk("fwd_enable", fwd_enable, 4'h2);
        peer_pdu(4'h2, 1'h1, 1'h0);
        cyc(2);
        chk("fwd_enable", fwd_enable, 4'h0);
        // Mode code 3 behaves as static bundling; two idle cycles keep a last passive frame out of the count
        reg_wr(lac_pkg::REG_CTRL, 32'h23);
        cyc(2);
        chk("fwd_enable", fwd_enable, 4'h2);
        count_tx(1, 0);
        $display("test passive done");
    endtask
    initial begin
        repeat (12) @(posedge clock);
        arst_n <= 1'h1;
        t_regs();
        t_reject();
        t_on_dist();
        t_active();
        t_passive();
        stop_test();
    end
endmodule
`default_nettype wire
